// [rtl/uart_ir_regs.vh]
`ifndef UART_IR_REGS_VH
`define UART_IR_REGS_VH

// Register byte offsets on the APB
`define MODE_OFS 8'h00
`define STA_OFS 8'h04
`define TXD_OFS 8'h08
`define RXD_OFS 8'h0C
`define BRG_OFS 8'h10

// Reset values and writable masks
`define MODE_RST 16'h0000
`define STA_RST 16'h0000
`define BRG_RST 16'h0000
`define MODE_WMASK 16'hBBFF
`define STA_WMASK 16'hECE0

// Mode register fields
`define M_EN 15
`define M_SIDL 13
`define M_INFRARED_CODEC_ENABLE 12
`define M_RTS_MODE_SELECT 11
`define M_UEN_HI 9
`define M_UEN_LO 8
`define M_WAKE 7
`define M_LPBK 6
`define M_AUTO_BAUD_ENABLE 5
`define M_RECEIVE_POLARITY_INVERT 4
`define M_HIGH_SPEED_SELECT 3
`define M_PD_HI 2
`define M_PD_LO 1
`define M_STOP_COUNT_SELECT 0

// Status and control register fields
`define S_TXIS1 15
`define S_TXINV 14
`define S_TXIS0 13
`define S_BRK 11
`define S_TXEN 10
`define S_TXBF 9
`define S_SHIFT_EMPTY_FLAG 8
`define S_RXIS_HI 7
`define S_RXIS_LO 6
`define S_ADDRESS_DETECT_ENABLE 5
`define S_RECEIVER_IDLE_FLAG 4
`define S_PARITY_ERROR_FLAG 3
`define S_FRAMING_ERROR_FLAG 2
`define S_OVERRUN_FLAG 1
`define S_RXDA 0

// Timing counts
`define SUB16 4'hF
`define SUB4 4'h3
`define IR_PULSE 4'h3
`define BREAK_LAST 4'hB
`define AB_EDGES 3'h4

`endif

// [rtl/uart_fifo4.v]
`timescale 1ns/100ps
module uart_fifo4 (
  // Clock and reset
  input wire ref_clk,
  input wire nrst,
  // Write side
  input wire flush,
  input wire push,
  input wire [10:0] din,
  // Read side
  input wire pop,
  output wire [10:0] dout,
  // Fill state
  output wire full,
  output wire empty,
  output wire [2:0] count
);
  reg [10:0] mem [0:3];
  reg [1:0] wptr;
  reg [1:0] rptr;
  reg [2:0] cnt;
  wire do_push = push & ~full;
  wire do_pop = pop & ~empty;

  assign dout = mem[rptr];
  assign full = cnt[2];
  assign empty = (cnt == 3'h0);
  assign count = cnt;

  always @(posedge ref_clk) begin
    if (!nrst || flush) begin
      wptr <= 2'h0;
      rptr <= 2'h0;
      cnt <= 3'h0;
    end else begin
      if (do_push) begin
        mem[wptr] <= din;
        wptr <= wptr + 2'h1;
      end
      if (do_pop)
        rptr <= rptr + 2'h1;
      if (do_push && !do_pop)
        cnt <= cnt + 3'h1;
      else if (do_pop && !do_push)
        cnt <= cnt - 3'h1;
    end
  end
endmodule // uart_fifo4

// [rtl/uart_baud_gen.v]
`timescale 1ns/100ps
module uart_baud_gen (
  // Clock and reset
  input wire ref_clk,
  input wire nrst,
  // Control
  input wire run,
  input wire clear,
  input wire [15:0] divisor,
  // Sub-bit tick and square clock
  output wire tick,
  output wire bclk
);
  reg [15:0] cnt;

  assign tick = run & (cnt == divisor);
  // High for the first half of each period
  assign bclk = run & (cnt <= {1'b0, divisor[15:1]});

  always @(posedge ref_clk) begin
    if (!nrst || clear)
      cnt <= 16'h0000;
    else if (tick)
      cnt <= 16'h0000;
    else if (run)
      cnt <= cnt + 16'h0001;
  end
endmodule // uart_baud_gen

// [rtl/uart_ir.v]
// Behaviour
// - Infrared coding acts only while high-speed select is clear.
// - Pin-enable 11 with module enabled drives the sub-bit clock (16x baud, 4x with high-speed select) on RTS pin.
// - Infrared enable routes receive and transmit pins through the codec.
// - Stop-in-idle halts the block while the system idles.
// - RTS mode select: set gives simplex, clear gives flow control.
// - High-speed select gives 4 sub-clocks per bit, else 16.
// - Parity/data field picks 9-bit, odd, even or no parity format.
// - Stop-count select gives two stop bits when set, else one.
// - Transmit interrupt on load, on all sent, or on buffer emptied.
// - Transmit invert sets idle level, opposite sense with codec on.
// - Send-break sends start, twelve zeros, stop, then clears itself.
// - Clearing transmit enable aborts, flushes buffer and releases pin.
// - Buffer-full flag shows the transmit buffer is full.
// - Shift-empty flag set only when shifter and buffer are both empty.
// - Receive interrupt on any character, on 3 held, or on 4 held.
// - Address detect in 9-bit mode keeps only ninth-bit-set characters.
// - Receiver-idle flag reads 1 unless a character is arriving.
// - Parity and framing flags belong to the character at buffer head.
// - Overflow sets overrun; clearing it empties buffer and shifter.
// - Data registers hold bits 8..0; bits above read zero.
// - Writing the baud divisor clears the baud timer.
// - Reading receive data advances the head with its own error flags.
// - Both directions have a four-entry buffer.
// - Setting transmit enable raises a transmit interrupt two cycles later.
`timescale 1ns/100ps
`include "uart_ir_regs.vh"
module uart_ir (
  // Clock and reset
  input wire ref_clk,
  input wire nrst,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Serial pins
  input wire receive_pin,
  input wire clear_to_send_pin,
  output reg transmit_pin,
  output reg transmit_pin_oe,
  output reg request_to_send_pin,
  output reg request_to_send_pin_oe,
  // System state and events
  input wire idle_mode,
  output reg tx_interrupt,
  output reg rx_interrupt
);
  localparam TX_IDLE = 5'h01;
  localparam TX_START = 5'h02;
  localparam TX_DATA = 5'h04;
  localparam TX_PAR = 5'h08;
  localparam TX_STOP = 5'h10;
  localparam RX_IDLE = 5'h01;
  localparam RX_START = 5'h02;
  localparam RX_DATA = 5'h04;
  localparam RX_PAR = 5'h08;
  localparam RX_STOP = 5'h10;

  function [3:0] sub_last;
    input hs;
    sub_last = hs ? `SUB4 : `SUB16;
  endfunction

  function par_bit;
    input [7:0] d;
    input odd;
    par_bit = (^d) ^ odd;
  endfunction

  reg [15:0] serial_mode_control;
  reg [15:0] serial_status_control;
  reg [15:0] baud_divisor;
  reg overrun_flag;

  wire module_enable = serial_mode_control[`M_EN];
  wire stop_in_idle = serial_mode_control[`M_SIDL];
  wire infrared_codec_enable = serial_mode_control[`M_INFRARED_CODEC_ENABLE];
  wire rts_mode_select = serial_mode_control[`M_RTS_MODE_SELECT];
  wire [1:0] pin_enable_field = serial_mode_control[`M_UEN_HI:`M_UEN_LO];
  wire wake_enable = serial_mode_control[`M_WAKE];
  wire loopback_select = serial_mode_control[`M_LPBK];
  wire auto_baud_enable = serial_mode_control[`M_AUTO_BAUD_ENABLE];
  wire receive_polarity_invert = serial_mode_control[`M_RECEIVE_POLARITY_INVERT];
  wire high_speed_select = serial_mode_control[`M_HIGH_SPEED_SELECT];
  wire [1:0] parity_data_select = serial_mode_control[`M_PD_HI:`M_PD_LO];
  wire stop_count_select = serial_mode_control[`M_STOP_COUNT_SELECT];
  wire [1:0] tx_interrupt_mode = {serial_status_control[`S_TXIS1],
                                  serial_status_control[`S_TXIS0]};
  wire tx_polarity_invert = serial_status_control[`S_TXINV];
  wire send_break = serial_status_control[`S_BRK];
  wire transmit_enable = serial_status_control[`S_TXEN];
  wire [1:0] rx_interrupt_mode = serial_status_control[`S_RXIS_HI:`S_RXIS_LO];
  wire address_detect_enable = serial_status_control[`S_ADDRESS_DETECT_ENABLE];

  wire nine = (parity_data_select == 2'h3);
  wire has_par = (parity_data_select == 2'h1) || (parity_data_select == 2'h2);
  wire [3:0] slast = sub_last(high_speed_select);
  wire [3:0] smid = {1'b0, slast[3:1]};
  wire ir_active = infrared_codec_enable & ~high_speed_select;
  wire halt = stop_in_idle & idle_mode;
  wire run = module_enable & ~halt;
  wire tx_on = module_enable & transmit_enable;

  // APB decode; one wait state, answer registered
  wire acc = psel & penable;
  wire xfer = acc & pready;
  wire hit = (paddr == `MODE_OFS) || (paddr == `STA_OFS) || (paddr == `TXD_OFS)
             || (paddr == `RXD_OFS) || (paddr == `BRG_OFS);
  wire mode_wr = xfer & pwrite & (paddr == `MODE_OFS);
  wire sta_wr = xfer & pwrite & (paddr == `STA_OFS);
  wire txd_wr = xfer & pwrite & (paddr == `TXD_OFS);
  wire brg_wr = xfer & pwrite & (paddr == `BRG_OFS);
  wire rxd_rd = xfer & ~pwrite & (paddr == `RXD_OFS);

  reg [4:0] tx_st;
  reg [3:0] tx_sub;
  reg [3:0] tx_bit;
  reg [8:0] tx_sh;
  reg tx_brk;
  reg tx_pv;
  reg [4:0] rx_st;
  reg [3:0] rx_sub;
  reg [3:0] rx_bit;
  reg [8:0] rx_sh;
  reg rx_pe;
  reg rx_prev;
  reg [3:0] ir_hold;
  reg [2:0] ab_edges;
  reg [23:0] ab_cnt;
  reg wake_armed;
  reg txen_d;
  reg txen_rise_d;
  reg [15:0] rd_mux;

  wire tick;
  wire bclk;
  wire [10:0] txf_dout;
  wire txf_full;
  wire txf_empty;
  wire [2:0] txf_cnt;
  wire [10:0] rxf_dout;
  wire rxf_full;
  wire rxf_empty;
  wire [2:0] rxf_cnt;

  // Transmit path
  wire txen_rise = transmit_enable & ~txen_d;
  wire txen_fall = ~transmit_enable & txen_d;
  wire cts_ok = (pin_enable_field != 2'h2) | ~clear_to_send_pin;
  wire tx_idle = tx_st[0];
  wire tx_pop = tick & tx_on & tx_idle & ~txf_empty & cts_ok;
  wire [3:0] tx_nb_last = tx_brk ? `BREAK_LAST : (nine ? 4'h8 : 4'h7);
  wire tx_done = tick & tx_st[4] & (tx_sub == slast) &
                 (tx_bit == {3'h0, stop_count_select});
  wire shift_empty_flag = txf_empty & tx_idle;
  reg tx_raw;

  always @* begin
    case (tx_st)
      TX_START: tx_raw = 1'b0;
      TX_DATA: tx_raw = tx_sh[0];
      TX_PAR: tx_raw = tx_pv;
      default: tx_raw = 1'b1;
    endcase
  end

  // Codec sends a short high pulse for each zero bit
  wire tx_enc = ~tx_raw & (tx_sub < `IR_PULSE);

  always @(posedge ref_clk) begin
    if (!nrst || !tx_on) begin
      tx_st <= TX_IDLE;
      tx_sub <= 4'h0;
      tx_bit <= 4'h0;
      tx_sh <= 9'h000;
      tx_brk <= 1'b0;
      tx_pv <= 1'b0;
    end else if (tick) begin
      case (tx_st)
        TX_IDLE: begin
          if (tx_pop) begin
            tx_st <= TX_START;
            tx_sub <= 4'h0;
            tx_brk <= send_break;
            tx_sh <= send_break ? 9'h000 : txf_dout[8:0];
            tx_pv <= par_bit(txf_dout[7:0], parity_data_select[1]);
          end
        end
        default: begin
          if (tx_sub != slast) begin
            tx_sub <= tx_sub + 4'h1;
          end else begin
            tx_sub <= 4'h0;
            case (tx_st)
              TX_START: begin
                tx_st <= TX_DATA;
                tx_bit <= 4'h0;
              end
              TX_DATA: begin
                tx_sh <= {1'b0, tx_sh[8:1]};
                if (tx_bit == tx_nb_last) begin
                  tx_bit <= 4'h0;
                  tx_st <= (has_par && !tx_brk) ? TX_PAR : TX_STOP;
                end else begin
                  tx_bit <= tx_bit + 4'h1;
                end
              end
              TX_PAR: tx_st <= TX_STOP;
              TX_STOP: begin
                if (tx_done)
                  tx_st <= TX_IDLE;
                else
                  tx_bit <= tx_bit + 4'h1;
              end
              default: tx_st <= TX_IDLE;
            endcase
          end
        end
      endcase
    end
  end

  // Receive path
  wire rx_pin_s = receive_pin ^ receive_polarity_invert;
  wire ir_dec = rx_pin_s & (ir_hold == 4'h0);
  wire rx_line = loopback_select ? tx_raw : (ir_active ? ir_dec : rx_pin_s);
  wire rx_fall = rx_prev & ~rx_line;
  wire rx_rise = ~rx_prev & rx_line;
  wire receiver_idle_flag = rx_st[0];
  wire rx_ev = tick & rx_st[4] & (rx_sub == smid);
  wire rx_accept = ~(address_detect_enable & nine & ~rx_sh[8]);
  wire ovr_set = rx_ev & rx_accept & rxf_full;
  wire rx_push = rx_ev & rx_accept & ~rxf_full;
  wire ovr_flush = sta_wr & ~pwdata[`S_OVERRUN_FLAG] & overrun_flag & ~ovr_set;
  wire [3:0] rx_nb_last = nine ? 4'h8 : 4'h7;

  // Decoder stretches each received pulse into a full low bit
  always @(posedge ref_clk) begin
    if (!nrst)
      ir_hold <= 4'h0;
    else if (!rx_pin_s)
      ir_hold <= slast;
    else if (tick && ir_hold != 4'h0)
      ir_hold <= ir_hold - 4'h1;
  end

  always @(posedge ref_clk) begin
    if (!nrst || !module_enable || ovr_flush) begin
      rx_st <= RX_IDLE;
      rx_sub <= 4'h0;
      rx_bit <= 4'h0;
      rx_sh <= 9'h000;
      rx_pe <= 1'b0;
    end else if (tick) begin
      case (rx_st)
        RX_IDLE: begin
          // Auto-baud owns the line until its measurement ends
          if (!rx_line && !auto_baud_enable) begin
            rx_st <= RX_START;
            rx_sub <= 4'h0;
            rx_sh <= 9'h000;
            rx_pe <= 1'b0;
          end
        end
        default: begin
          if (rx_sub == smid) begin
            case (rx_st)
              RX_START: if (rx_line) rx_st <= RX_IDLE;
              RX_DATA: rx_sh[rx_bit] <= rx_line;
              RX_PAR: rx_pe <= rx_line ^ par_bit(rx_sh[7:0], parity_data_select[1]);
              RX_STOP: rx_st <= RX_IDLE;
              default: rx_st <= RX_IDLE;
            endcase
          end
          if (rx_sub == slast) begin
            rx_sub <= 4'h0;
            case (rx_st)
              RX_START: begin
                rx_st <= RX_DATA;
                rx_bit <= 4'h0;
              end
              RX_DATA: begin
                if (rx_bit == rx_nb_last)
                  rx_st <= has_par ? RX_PAR : RX_STOP;
                else
                  rx_bit <= rx_bit + 4'h1;
              end
              RX_PAR: rx_st <= RX_STOP;
              default: rx_st <= RX_IDLE;
            endcase
          end else begin
            rx_sub <= rx_sub + 4'h1;
          end
        end
      endcase
    end
  end

  // Auto-baud: five falling edges of 55h span eight bit times
  wire [15:0] ab_q = high_speed_select ? ab_cnt[20:5] : ab_cnt[22:7];
  wire ab_done = auto_baud_enable & rx_fall & (ab_edges == `AB_EDGES);

  always @(posedge ref_clk) begin
    if (!nrst || !auto_baud_enable || !module_enable) begin
      ab_edges <= 3'h0;
      ab_cnt <= 24'h00_0000;
    end else begin
      if (ab_edges != 3'h0)
        ab_cnt <= ab_cnt + 24'h00_0001;
      if (rx_fall)
        ab_edges <= (ab_edges == `AB_EDGES) ? 3'h0 : ab_edges + 3'h1;
    end
  end

  // Wake-up watch on the receive line
  wire wake_irq = wake_enable & rx_fall;
  wire wake_clr = wake_enable & wake_armed & rx_rise;

  always @(posedge ref_clk) begin
    if (!nrst || !wake_enable)
      wake_armed <= 1'b0;
    else if (rx_fall)
      wake_armed <= 1'b1;
  end

  always @(posedge ref_clk) begin
    if (!nrst) begin
      rx_prev <= 1'b1;
      txen_d <= 1'b0;
      txen_rise_d <= 1'b0;
    end else begin
      rx_prev <= rx_line;
      txen_d <= transmit_enable;
      txen_rise_d <= txen_rise;
    end
  end

  // Software registers; software writes land after hardware clears
  always @(posedge ref_clk) begin
    if (!nrst) begin
      serial_mode_control <= `MODE_RST;
      serial_status_control <= `STA_RST;
      baud_divisor <= `BRG_RST;
    end else begin
      if (ab_done) begin
        serial_mode_control[`M_AUTO_BAUD_ENABLE] <= 1'b0;
        baud_divisor <= (ab_q == 16'h0000) ? 16'h0000 : ab_q - 16'h0001;
      end
      if (wake_clr)
        serial_mode_control[`M_WAKE] <= 1'b0;
      if (tx_done && tx_brk)
        serial_status_control[`S_BRK] <= 1'b0;
      if (mode_wr)
        serial_mode_control <= pwdata[15:0] & `MODE_WMASK;
      if (sta_wr)
        serial_status_control <= pwdata[15:0] & `STA_WMASK;
      if (brg_wr)
        baud_divisor <= pwdata[15:0];
    end
  end

  // Hardware set wins over a software clear
  always @(posedge ref_clk) begin
    if (!nrst)
      overrun_flag <= 1'b0;
    else if (ovr_set)
      overrun_flag <= 1'b1;
    else if (sta_wr && !pwdata[`S_OVERRUN_FLAG])
      overrun_flag <= 1'b0;
  end

  uart_baud_gen u_baud (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .run(run),
    .clear(brg_wr | ab_done | txen_rise),
    .divisor(baud_divisor),
    .tick(tick),
    .bclk(bclk)
  );

  uart_fifo4 u_txf (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .flush(txen_fall),
    .push(txd_wr),
    .din({2'h0, nine & pwdata[8], pwdata[7:0]}),
    .pop(tx_pop),
    .dout(txf_dout),
    .full(txf_full),
    .empty(txf_empty),
    .count(txf_cnt)
  );

  uart_fifo4 u_rxf (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .flush(ovr_flush),
    .push(rx_push),
    .din({~rx_line, rx_pe, nine & rx_sh[8], rx_sh[7:0]}),
    .pop(rxd_rd),
    .dout(rxf_dout),
    .full(rxf_full),
    .empty(rxf_empty),
    .count(rxf_cnt)
  );

  always @* begin
    case (paddr)
      `MODE_OFS: rd_mux = serial_mode_control;
      // An empty buffer reads as zero, not as its stale or unwritten slot
      `STA_OFS: rd_mux = serial_status_control |
        {6'h00, txf_full, shift_empty_flag, 3'h0, receiver_idle_flag,
         rxf_dout[9] & ~rxf_empty, rxf_dout[10] & ~rxf_empty, overrun_flag,
         ~rxf_empty};
      `RXD_OFS: rd_mux = rxf_empty ? 16'h0000 : {7'h00, rxf_dout[8:0]};
      `BRG_OFS: rd_mux = baud_divisor;
      default: rd_mux = 16'h0000;
    endcase
  end

  always @(posedge ref_clk) begin
    if (!nrst) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= acc & ~pready;
      if (acc && !pready) begin
        prdata <= {16'h0000, rd_mux};
        pslverr <= ~hit;
      end
    end
  end

  // Pins and events
  always @(posedge ref_clk) begin
    if (!nrst) begin
      transmit_pin <= 1'b1;
      transmit_pin_oe <= 1'b0;
      request_to_send_pin <= 1'b1;
      request_to_send_pin_oe <= 1'b0;
      tx_interrupt <= 1'b0;
      rx_interrupt <= 1'b0;
    end else begin
      transmit_pin_oe <= tx_on;
      transmit_pin <= (ir_active ? tx_enc : tx_raw) ^ tx_polarity_invert;
      request_to_send_pin_oe <= module_enable & (pin_enable_field != 2'h0);
      if (pin_enable_field == 2'h3)
        request_to_send_pin <= bclk;
      else if (rts_mode_select)
        request_to_send_pin <= shift_empty_flag;
      else
        request_to_send_pin <= rxf_full;
      tx_interrupt <= (tx_pop && tx_interrupt_mode == 2'h0) ||
                      (tx_pop && tx_interrupt_mode == 2'h2 && txf_cnt == 3'h1) ||
                      (tx_done && tx_interrupt_mode == 2'h1 && txf_empty) ||
                      txen_rise_d;
      rx_interrupt <= wake_irq ||
                      (rx_push && rx_interrupt_mode == 2'h3 && rxf_cnt == 3'h3) ||
                      (rx_push && rx_interrupt_mode == 2'h2 && rxf_cnt == 3'h2) ||
                      (rx_push && !rx_interrupt_mode[1]);
    end
  end
endmodule // uart_ir

// [sim/uart_ir_checker.sv]
`timescale 1ns/100ps
`include "uart_ir_regs.vh"
module uart_ir_checker (
  // Clock and reset
  input wire ref_clk,
  input wire nrst,
  // APB
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  // Pins and events
  input wire transmit_pin_oe,
  input wire request_to_send_pin,
  input wire request_to_send_pin_oe,
  input wire tx_interrupt
);
  // Shadow of the controls, taken only at the edge where a write completes
  reg [15:0] mode;
  reg tx_on;
  wire wr_done = psel && penable && pready && pwrite;
  wire bclk_on = mode[15] && mode[9:8] == 2'b11;
  always @(posedge ref_clk) begin
    if (!nrst) begin
      mode <= 16'h0000;
      tx_on <= 1'b0;
    end else if (wr_done && paddr == `MODE_OFS) begin
      mode <= pwdata[15:0];
    end else if (wr_done && paddr == `STA_OFS) begin
      tx_on <= pwdata[10];
    end
  end
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);
  sequence done_s;
    psel && penable && pready;
  endsequence
  sequence rx_read_s;
    done_s ##0 (!pwrite && paddr == `RXD_OFS);
  endsequence
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready held past one cycle");
  ready_access_a: assert property (pready |-> psel && penable && $past(penable))
    else $error("pready outside the second access cycle");
  err_decode_a: assert property (done_s |-> pslverr == (paddr > `BRG_OFS || paddr[1:0] != 2'b00))
    else $error("pslverr does not match the address map");
  rx_upper_a: assert property (rx_read_s |-> prdata[31:9] == 23'h0)
    else $error("receive data upper bits not zero");
  txen_irq_a: assert property ($rose(tx_on) && mode[15] |-> ##[1:2] tx_interrupt)
    else $error("no transmit interrupt after transmit enable");
  pins_off_a: assert property (!mode[15] && !$past(mode[15]) |-> !transmit_pin_oe && !request_to_send_pin_oe)
    else $error("pins driven while module disabled");
  tx_off_a: assert property (!tx_on && !$past(tx_on) |-> !transmit_pin_oe)
    else $error("transmit pin driven while transmit disabled");
  bclk_oe_a: assert property (bclk_on && $past(bclk_on) |-> request_to_send_pin_oe)
    else $error("baud clock pin not driven");
  bclk_run_a: assert property (bclk_on [*2] |-> ##[1:40] ($changed(request_to_send_pin) || !bclk_on))
    else $error("baud clock pin not toggling");
endmodule // uart_ir_checker
bind uart_ir uart_ir_checker chk (.ref_clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata,
  .prdata, .pready, .pslverr, .transmit_pin_oe, .request_to_send_pin, .request_to_send_pin_oe,
  .tx_interrupt);

// [sim/serial_peer.sv]
`timescale 1ns/100ps
module serial_peer #(
  parameter BIT = 16
) (
  // Clock
  input wire ref_clk,
  // Line from the block
  input wire line_in,
  input wire listen,
  output reg [22:0] frame,
  output reg frame_done,
  // Line into the block
  output reg line_out
);
  integer j;
  initial begin
    line_out = 1'b1;
    frame = 23'h00_0000;
    frame_done = 1'b0;
    forever begin
      @(posedge ref_clk);
      frame_done <= 1'b0;
      if (listen && !line_in) begin
        // Sample mid-bit so edge jitter of a cycle does not matter
        repeat (BIT / 2) @(posedge ref_clk);
        for (j = 0; j < 23; j = j + 1) begin
          repeat (BIT) @(posedge ref_clk);
          frame[j] <= line_in;
        end
        frame_done <= 1'b1;
      end
    end
  end
  task send(input [22:0] v, input integer n);
    integer k;
    begin
      line_out <= 1'b0;
      repeat (BIT) @(posedge ref_clk);
      for (k = 0; k < n; k = k + 1) begin
        line_out <= v[k];
        repeat (BIT) @(posedge ref_clk);
      end
      line_out <= 1'b1;
      repeat (BIT) @(posedge ref_clk);
    end
  endtask
endmodule // serial_peer

// [sim/uart_with_infrared_codec_tb.sv]
`timescale 1ns/100ps
`include "uart_ir_regs.vh"
`define CHK(nm, e, s) begin n_compared = n_compared + 1; if ((e) !== (s)) begin \
  errors = errors + 1; $display("BAD %s exp %h got %h", nm, e, s); end end
module uart_with_infrared_codec_tb;
  reg ref_clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  reg idle_mode = 1'b0, listen = 1'b1;
  reg [7:0] paddr = 8'h00;
  reg [31:0] pwdata = 32'h0000_0000;
  reg [31:0] rq[$], mq[$], e, m;
  reg [22:0] fq[$], f;
  reg [8:0] x, y;
  reg [7:0] sent [0:4];
  integer errors = 0, n_compared = 0, seed = 32'h94f3, i, t, n_rx = 0;
  wire [31:0] prdata;
  wire [22:0] frame;
  wire pready, pslverr, tx_pin, tx_oe, rts, rts_oe, tx_irq, rx_irq, rx_pin, done;
  // Port latch keeps the released line at its idle mark level
  wire tx_line = tx_oe ? tx_pin : 1'b1;
  uart_ir dut (.ref_clk(ref_clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .receive_pin(rx_pin), .clear_to_send_pin(1'b0), .transmit_pin(tx_pin),
    .transmit_pin_oe(tx_oe), .request_to_send_pin(rts), .request_to_send_pin_oe(rts_oe),
    .idle_mode(idle_mode), .tx_interrupt(tx_irq), .rx_interrupt(rx_irq));
  serial_peer #(.BIT(16)) peer (.ref_clk(ref_clk), .line_in(tx_line), .listen(listen),
    .frame(frame), .frame_done(done), .line_out(rx_pin));
  initial begin
    forever #2.5 ref_clk = ~ref_clk;
  end
  task end_of_test;
    begin
      $display("compared %0d errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) begin
        $display("== PASSED ==");
      end else begin
        $display("== FAILED ==");
      end
      $finish;
    end
  endtask
  task apb(input [7:0] a, input w, input [31:0] d);
    begin
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      t = 0;
      do begin
        @(posedge ref_clk);
        t = t + 1;
      end while (pready !== 1'b1 && t < 20);
      psel <= 1'b0;
      penable <= 1'b0;
      if (t == 20) begin
        errors = errors + 1;
        end_of_test;
      end
    end
  endtask
  task rchk(input [7:0] a, input [31:0] ev, input [31:0] mv);
    begin
      rq.push_back(ev);
      mq.push_back(mv);
      apb(a, 1'b0, 32'h0000_0000);
    end
  endtask
  task wait_q;
    begin
      t = 0;
      while (fq.size() > 0 && t < 2000) begin
        @(posedge ref_clk);
        t = t + 1;
      end
      if (t == 2000) begin
        errors = errors + 1;
        end_of_test;
      end
    end
  endtask
  // Bits after the start bit: one or two characters back to back, idle mark after
  function [22:0] fr(input [1:0] pd, input st, input two, input [8:0] a, input [8:0] b);
    integer n, j, k;
    reg [8:0] c;
    begin
      fr = {23{1'b1}};
      n = 0;
      for (j = 0; j <= two; j = j + 1) begin
        c = j ? b : a;
        for (k = 0; k < 8 + (pd != 2'b00); k = k + 1) begin
          fr[n] = k < 8 ? c[k] : (pd == 2'b11 ? c[8] : (pd == 2'b01 ? ^c[7:0] : ~^c[7:0]));
          n = n + 1;
        end
        n = n + 1 + st;
        if (j == 0 && two) begin
          fr[n] = 1'b0;
          n = n + 1;
        end
      end
    end
  endfunction
  always @(posedge ref_clk) begin
    if (psel && penable && pready === 1'b1 && !pwrite && rq.size() > 0) begin
      e = rq.pop_front();
      m = mq.pop_front();
      `CHK("read", e, prdata & m)
    end
    if (done === 1'b1) begin
      f = fq.pop_front();
      `CHK("frame", f, frame)
    end
    if (rx_irq === 1'b1)
      n_rx = n_rx + 1;
  end
  initial begin
    repeat (4) @(posedge ref_clk);
    nrst <= 1'b1;
    rchk(`MODE_OFS, 32'h0000_0000, 32'hFFFF_FFFF);
    rchk(8'h14, 32'h0000_0000, 32'hFFFF_FFFF);
    // Divisor 1, so that the registered baud clock output can toggle
    apb(`BRG_OFS, 1'b1, 32'h0000_0001);
    apb(`MODE_OFS, 1'b1, 32'h0000_8300);
    repeat (60) @(posedge ref_clk);
    apb(`BRG_OFS, 1'b1, 32'h0000_0000);
    // Inverted idle levels would look like start bits to the peer
    listen <= 1'b0;
    for (i = 0; i < 4; i = i + 1) begin
      apb(`MODE_OFS, 1'b1, 32'h0000_8000 | (i[1] << 12));
      apb(`STA_OFS, 1'b1, 32'h0000_0400 | (i[0] << 14));
      repeat (4) @(posedge ref_clk);
      `CHK("idle level", ~(i[1] ^ i[0]), tx_line)
    end
    apb(`STA_OFS, 1'b1, 32'h0000_0400);
    for (i = 0; i < 4; i = i + 1) begin
      idle_mode <= i[1];
      x = $random(seed);
      y = $random(seed);
      apb(`MODE_OFS, 1'b1, 32'h0000_8000 | (i << 1) | i[0]);
      fq.push_back(fr(i[1:0], i[0], 1'b1, x, y));
      apb(`TXD_OFS, 1'b1, {23'h0, x});
      listen <= 1'b1;
      apb(`TXD_OFS, 1'b1, {23'h0, y});
      rchk(`STA_OFS, 32'h0000_0000, 32'h0000_0300);
      wait_q;
    end
    apb(`MODE_OFS, 1'b1, 32'h0000_8000);
    fq.push_back(23'h7F_F000);
    apb(`STA_OFS, 1'b1, 32'h0000_0C00);
    apb(`TXD_OFS, 1'b1, 32'h0000_0000);
    wait_q;
    rchk(`STA_OFS, 32'h0000_0100, 32'h0000_0900);
    apb(`MODE_OFS, 1'b1, 32'h0000_A000);
    idle_mode <= 1'b1;
    apb(`TXD_OFS, 1'b1, 32'h0000_003C);
    repeat (100) @(posedge ref_clk);
    rchk(`STA_OFS, 32'h0000_0000, 32'h0000_0100);
    fq.push_back(fr(2'b00, 1'b0, 1'b0, 9'h03C, 9'h03C));
    idle_mode <= 1'b0;
    wait_q;
    listen <= 1'b0;
    apb(`STA_OFS, 1'b1, 32'h0000_0000);
    for (i = 0; i < 5; i = i + 1) begin
      apb(`TXD_OFS, 1'b1, 32'h0000_00A5);
    end
    rchk(`STA_OFS, 32'h0000_0200, 32'h0000_0300);
    apb(`STA_OFS, 1'b1, 32'h0000_0400);
    apb(`STA_OFS, 1'b1, 32'h0000_0000);
    rchk(`STA_OFS, 32'h0000_0100, 32'h0000_0300);
    apb(`MODE_OFS, 1'b1, 32'h0000_8002);
    rchk(`STA_OFS, 32'h0000_0010, 32'h0000_0010);
    for (i = 0; i < 5; i = i + 1) begin
      x = $random(seed);
      sent[i] = x[7:0];
      fork
        peer.send(fr(2'b01, 1'b0, 1'b0, x, x) ^ (i == 0 ? 23'h100 : 23'h0), 11);
        begin
          repeat (40) @(posedge ref_clk);
          rchk(`STA_OFS, 32'h0000_0000, 32'h0000_0010);
        end
      join
    end
    `CHK("rx irq", 4, n_rx)
    rchk(`STA_OFS, 32'h0000_000B, 32'h0000_000F);
    rchk(`RXD_OFS, {24'h0, sent[0]}, 32'hFFFF_FFFF);
    rchk(`STA_OFS, 32'h0000_0003, 32'h0000_000F);
    rchk(`RXD_OFS, {24'h0, sent[1]}, 32'hFFFF_FFFF);
    apb(`STA_OFS, 1'b1, 32'h0000_0000);
    rchk(`STA_OFS, 32'h0000_0000, 32'h0000_0003);
    listen <= 1'b1;
    apb(`MODE_OFS, 1'b1, 32'h0000_8006);
    apb(`STA_OFS, 1'b1, 32'h0000_0020);
    peer.send(fr(2'b11, 1'b0, 1'b0, 9'h05A, 9'h05A), 11);
    peer.send(fr(2'b11, 1'b0, 1'b0, 9'h1C3, 9'h1C3), 11);
    rchk(`RXD_OFS, 32'h0000_01C3, 32'hFFFF_FFFF);
    rchk(`STA_OFS, 32'h0000_0000, 32'h0000_0001);
    end_of_test;
  end
endmodule // uart_with_infrared_codec_tb
